// ===== rtl/pdd_dispatch.sv
// The Avalon-MM slave port and the address map were decided locally.
`timescale 1ns/10ps
// Notes on behaviour
// [RQ1] Hierarchical resolve bit 9 makes rendering update hierarchical depth to match depth.
// [RQ2] After hierarchical resolve the hierarchical buffer is left initialized and ineffective.
// [RQ3] Depth resolve bit 8 makes rendering update depth to match hierarchical depth.
// [RQ4] Both resolve bits are ignored while hierarchical depth is disabled.
// [RQ5] Software enables at most one of the three depth operations.
// [RQ6] Depth clear bit 7 makes rendering initialize the depth buffer.
// [RQ7] Software disables the depth test while depth clear is on.
// [RQ8] Fast span coverage marks every touched aligned 4x4 pixel block fully covered.
// [RQ9] Software enables depth clear whenever fast span coverage is on.
// [RQ10] Software uses fast span only for rectangles aligned to a 4x4 grid.
// [RQ11] Contiguous 64-pixel mode packs 16 subspans only as a full 8x8 block.
// [RQ12] Contiguous 32-pixel mode packs 8 subspans only as a full 8x4 block.
// [RQ13] The 32-pixel bit allows 8 subspans per payload; clear forbids it.
// [RQ14] The 16-pixel bit allows 4 subspans per payload, the usual mode.
// [RQ15] The 8-pixel bit allows 2 subspans per payload.
// [RQ16] Four kernel entry offsets and block counts, selected by payload size.
// [RQ17] Depth bias constant is a 32-bit float in bits 31:0.
// [RQ18] Depth bias slope term is a 32-bit float in its own word.
// [RQ19] Kernel entry offsets sit in bits 31:6, 64-byte aligned.
// [RQ20] Block counts sit in bits 3:1 as blocks minus one.
// [RQ21] Software rounds register use up to multiples of sixteen.
// [RQ22] Subspans are 2x2 pixel groups, the unit of every dispatch size.
// [RQ23] Software turns statistics off during any depth operation.
// [RQ24] Payload sizes are chosen per group from the enabled sizes only; with bits 2:0 all clear the code still issues 4-subspan payloads.
// [RQ25] Reserved state bits are ignored and read as zero.
module pdd_dispatch (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic [5:0]               address,
    input  wire logic                     read,
    input  wire logic                     write,
    input  wire logic [31:0]              writedata,
    input  wire logic [3:0]               byteenable,
    output logic      [31:0]              readdata,
    output logic                          waitrequest,
    input  wire logic                     blk_valid,
    input  wire pdd_pkg::pdd_block_type   blk,
    output logic                          blk_ready,
    output logic                          pay_valid,
    output pdd_pkg::pdd_payload_type      pay,
    input  wire logic                     pay_ready,
    output logic      [31:0]              bias_const,
    output logic      [31:0]              bias_scale
);

    logic [31:0]                  ctrl;
    logic                         hiz_en;
    logic [25:0]                  kern_entry [4];
    logic [2:0]                   kern_blocks [4];
    logic [15:0]                  pay_count;
    logic                         ack;
    logic [3:0]                   idx;
    logic [pdd_pkg::SUBSPANS-1:0] rem;
    logic [pdd_pkg::PIXELS-1:0]   cur_pix;
    logic                         busy;
    logic                         load;
    logic                         issue;
    logic [pdd_pkg::SUBSPANS-1:0] take;
    pdd_pkg::pdd_size_type        next_size;
    logic                         next_contig;
    logic [pdd_pkg::PIXELS-1:0]   cov_pix;
    logic [1:0]                   kern_sel;
    logic [31:0]                  kern_merged;

    // Byte-lane merge of a write into a stored word.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = val[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Keeps the first n set subspans of a mask in raster order.
    function automatic logic [15:0] first_n(input logic [15:0] m, input int n);
        logic [15:0] r;
        int          c;
        r = 16'h0000;
        c = 0;
        for (int i = 0; i < 16; i++) begin
            if (m[i] && c < n) begin
                r[i] = 1'b1;
                c = c + 1;
            end
        end
        return r;
    endfunction

    // Counts set subspans.
    function automatic int count(input logic [15:0] m);
        int c;
        c = 0;
        for (int i = 0; i < 16; i++) begin
            c = c + int'(m[i]);
        end
        return c;
    endfunction

    // Subspan s = row*4+col is present when any of its 2x2 pixels is lit.
    function automatic logic [15:0] to_subspans(input logic [63:0] p);
        logic [15:0] r;
        for (int s = 0; s < 16; s++) begin
            r[s] = p[(s/4)*16 + (s%4)*2] | p[(s/4)*16 + (s%4)*2 + 1]
                 | p[(s/4)*16 + (s%4)*2 + 8] | p[(s/4)*16 + (s%4)*2 + 9]; // RQ22
        end
        return r;
    endfunction

    assign idx = address[5:2];

    // Kernel words sit at indices 8 to 11; index 11 wraps round to slot zero.
    // The merge is kept in its own word because a function result cannot be part-selected.
    assign kern_sel    = 2'(idx - pdd_pkg::IDX_KERNEL1 + 4'h1);
    assign kern_merged = merge({kern_entry[kern_sel], 6'h00}, writedata, byteenable);

    // The bus answers one cycle after a request is seen, so waitrequest drops on the second cycle.
    assign waitrequest = (read | write) & ~ack;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack <= 1'b0;
        end else begin
            ack <= (read | write) & ~ack;
        end
    end

    // Register writes take effect on the edge where waitrequest is low.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl       <= pdd_pkg::CTRL_RESET;
            bias_const <= pdd_pkg::WORD_RESET;
            bias_scale <= pdd_pkg::WORD_RESET;
            hiz_en     <= 1'b0;
        end else if (write && ack) begin
            unique case (idx)
                pdd_pkg::IDX_DISPATCH_CTRL: begin
                    ctrl <= merge(ctrl, writedata, byteenable) & pdd_pkg::CTRL_WRITE_MASK; // RQ25
                end
                pdd_pkg::IDX_BIAS_CONST: begin
                    bias_const <= merge(bias_const, writedata, byteenable); // RQ17
                end
                pdd_pkg::IDX_BIAS_SCALE: begin
                    bias_scale <= merge(bias_scale, writedata, byteenable); // RQ18
                end
                pdd_pkg::IDX_DEPTH_CFG: begin
                    if (byteenable[0]) begin
                        hiz_en <= writedata[0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Kernel table; the low address bits and the reserved bits are never stored.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int k = 0; k < 4; k++) begin
                kern_entry[k]  <= 26'h000_0000;
                kern_blocks[k] <= 3'h0;
            end
        end else if (write && ack && idx >= pdd_pkg::IDX_KERNEL1 && idx <= pdd_pkg::IDX_KERNEL0) begin
            kern_entry[kern_sel]  <= kern_merged[31:pdd_pkg::ENTRY_LSB]; // RQ19
            kern_blocks[kern_sel] <= byteenable[0] ? writedata[pdd_pkg::BLOCKS_LSB +: 3] : kern_blocks[kern_sel]; // RQ20
        end
    end

    // Read data is registered at the edge that raises ack, before the answering cycle; unmapped words read zero.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            readdata <= 32'h0000_0000;
        end else if (read && !ack) begin
            unique case (idx)
                pdd_pkg::IDX_DISPATCH_CTRL: readdata <= ctrl;
                pdd_pkg::IDX_BIAS_CONST:    readdata <= bias_const;
                pdd_pkg::IDX_BIAS_SCALE:    readdata <= bias_scale;
                pdd_pkg::IDX_KERNEL1,
                pdd_pkg::IDX_KERNEL2,
                pdd_pkg::IDX_KERNEL3,
                pdd_pkg::IDX_KERNEL0: begin
                    readdata <= {kern_entry[kern_sel], 2'b00, kern_blocks[kern_sel], 1'b0};
                end
                pdd_pkg::IDX_STATUS:        readdata <= {pay_count, 14'h0000, pay_valid, busy};
                pdd_pkg::IDX_DEPTH_CFG:     readdata <= {31'h0000_0000, hiz_en};
                default:                    readdata <= 32'h0000_0000;
            endcase
        end
    end

    // Fast span coverage fills each aligned 4x4 quadrant that has any lit pixel.
    always_comb begin
        cov_pix = blk.pixel_mask;
        if (ctrl[pdd_pkg::BIT_FAST_SPAN]) begin
            for (int q = 0; q < 4; q++) begin
                for (int p = 0; p < 16; p++) begin
                    if (|{blk.pixel_mask[(q/2)*32 + (q%2)*4 +: 4], blk.pixel_mask[(q/2)*32 + (q%2)*4 + 8 +: 4],
                          blk.pixel_mask[(q/2)*32 + (q%2)*4 + 16 +: 4], blk.pixel_mask[(q/2)*32 + (q%2)*4 + 24 +: 4]}) begin
                        cov_pix[(q/2)*32 + (q%2)*4 + (p/4)*8 + (p%4)] = 1'b1; // RQ8
                    end
                end
            end
        end
    end

    // Payload sizing: contiguous modes first, then 8 subspans for more than 4 left, 4 for more than 2, else 2;
    // a disabled size falls to the next smaller enabled one, else the nearest larger; with none enabled, 4.
    always_comb begin
        next_contig = 1'b0;
        next_size   = pdd_pkg::PDD_SZ4;
        take        = first_n(rem, 4);
        if (ctrl[pdd_pkg::BIT_CONTIG64] && rem == 16'hFFFF) begin
            next_size   = pdd_pkg::PDD_SZ16; // RQ11
            next_contig = 1'b1;
            take        = rem;
        end else if (ctrl[pdd_pkg::BIT_CONTIG32] && rem[7:0] == 8'hFF) begin
            next_size   = pdd_pkg::PDD_SZ8; // RQ12
            next_contig = 1'b1;
            take        = 16'h00FF;
        end else if (ctrl[pdd_pkg::BIT_CONTIG32] && rem[15:8] == 8'hFF) begin
            next_size   = pdd_pkg::PDD_SZ8; // RQ12
            next_contig = 1'b1;
            take        = 16'hFF00;
        end else if (ctrl[pdd_pkg::BIT_DISP32] && (count(rem) > 4 || !(ctrl[pdd_pkg::BIT_DISP16] || ctrl[pdd_pkg::BIT_DISP8]))) begin
            next_size = pdd_pkg::PDD_SZ8; // RQ13 RQ24
            take      = first_n(rem, 8);
        end else if (ctrl[pdd_pkg::BIT_DISP16] && (count(rem) > 2 || !ctrl[pdd_pkg::BIT_DISP8])) begin
            next_size = pdd_pkg::PDD_SZ4; // RQ14 RQ24
            take      = first_n(rem, 4);
        end else if (ctrl[pdd_pkg::BIT_DISP8]) begin
            next_size = pdd_pkg::PDD_SZ2; // RQ15 RQ24
            take      = first_n(rem, 2);
        end
    end

    assign busy      = |rem;
    assign blk_ready = ~busy;
    assign load      = blk_valid & blk_ready;
    assign issue     = busy & (~pay_valid | pay_ready);

    // Remaining subspans of the current block; an empty block is dropped at once.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rem     <= 16'h0000;
            cur_pix <= 64'h0000_0000_0000_0000;
        end else if (load) begin
            rem     <= to_subspans(cov_pix);
            cur_pix <= cov_pix;
        end else if (issue) begin
            rem <= rem & ~take;
        end
    end

    // Output payload register; the kernel is selected by the payload size.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pay_valid <= 1'b0;
            pay       <= '0;
        end else if (issue) begin
            pay_valid         <= 1'b1;
            pay.size          <= next_size;
            pay.contiguous    <= next_contig;
            pay.kernel        <= 2'(next_size);
            pay.entry         <= kern_entry[2'(next_size)]; // RQ16
            pay.blocks        <= kern_blocks[2'(next_size)]; // RQ16
            pay.subspans      <= take;
            pay.pixel_mask    <= cur_pix;
            pay.hier_resolve  <= ctrl[pdd_pkg::BIT_HIER_RESOLVE] & hiz_en; // RQ1 RQ4
            pay.hiz_reinit    <= ctrl[pdd_pkg::BIT_HIER_RESOLVE] & hiz_en; // RQ2
            pay.depth_resolve <= ctrl[pdd_pkg::BIT_DEPTH_RESOLVE] & hiz_en; // RQ3 RQ4
            pay.depth_clear   <= ctrl[pdd_pkg::BIT_DEPTH_CLEAR]; // RQ6
        end else if (pay_ready) begin
            pay_valid <= 1'b0;
        end
    end

    // Count of issued payloads, wrapping, for software to watch progress.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pay_count <= 16'h0000;
        end else if (issue) begin
            pay_count <= pay_count + 16'h0001;
        end
    end

    a_hier_gate: assert property (@(posedge clk) disable iff (rst) issue |=> pay.hier_resolve == ($past(ctrl[9]) && $past(hiz_en)) && pay.hiz_reinit == pay.hier_resolve) else $error("hier resolve flag wrong"); // RQ1 RQ2 RQ4
    a_resolve_gate: assert property (@(posedge clk) disable iff (rst) issue |=> pay.depth_resolve == ($past(ctrl[8]) && $past(hiz_en))) else $error("depth resolve flag wrong"); // RQ3
    a_clear_flag: assert property (@(posedge clk) disable iff (rst) issue |=> pay.depth_clear == $past(ctrl[7])) else $error("depth clear flag wrong"); // RQ6
    a_full_sixteen: assert property (@(posedge clk) disable iff (rst) pay_valid && pay.size == pdd_pkg::PDD_SZ16 |-> pay.subspans == 16'hFFFF && pay.contiguous) else $error("sixteen not full block"); // RQ11
    a_half_eight: assert property (@(posedge clk) disable iff (rst) pay_valid && pay.contiguous && pay.size == pdd_pkg::PDD_SZ8 |-> pay.subspans == 16'h00FF || pay.subspans == 16'hFF00) else $error("contiguous eight not half block"); // RQ12
    a_size_enabled: assert property (@(posedge clk) disable iff (rst) issue && !next_contig && (ctrl[2] || ctrl[1] || ctrl[0]) |-> (next_size == pdd_pkg::PDD_SZ8 && ctrl[2]) || (next_size == pdd_pkg::PDD_SZ4 && ctrl[1]) || (next_size == pdd_pkg::PDD_SZ2 && ctrl[0])) else $error("disabled size used"); // RQ13 RQ14 RQ15 RQ24
    a_kernel_pick: assert property (@(posedge clk) disable iff (rst) issue && !(write && ack) |=> pay.entry == kern_entry[pay.kernel] && pay.blocks == kern_blocks[pay.kernel]) else $error("kernel mismatch"); // RQ16
    a_fast_cover: assert property (@(posedge clk) disable iff (rst) load && ctrl[6] && |blk.pixel_mask[3:0] |=> (cur_pix[27:0] & 28'hF0F_0F0F) == 28'hF0F_0F0F) else $error("quadrant not filled"); // RQ8
    a_bus_answer: assert property (@(posedge clk) disable iff (rst) (read || write) && waitrequest |=> !waitrequest) else $error("bus answer late"); // RQ25
    a_drain_block: assert property (@(posedge clk) disable iff (rst) issue |=> (rem & pay.subspans) == 16'h0000) else $error("subspan issued twice"); // RQ22

endmodule

// ===== rtl/pdd_pkg.sv
package pdd_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [3:0] IDX_DISPATCH_CTRL = 4'h5;
    localparam logic [3:0] IDX_BIAS_CONST    = 4'h6;
    localparam logic [3:0] IDX_BIAS_SCALE    = 4'h7;
    localparam logic [3:0] IDX_KERNEL1       = 4'h8;
    localparam logic [3:0] IDX_KERNEL2       = 4'h9;
    localparam logic [3:0] IDX_KERNEL3       = 4'hA;
    localparam logic [3:0] IDX_KERNEL0       = 4'hB;
    localparam logic [3:0] IDX_STATUS        = 4'hC;
    localparam logic [3:0] IDX_DEPTH_CFG     = 4'hD;

    // Dispatch control bit positions.
    localparam int BIT_HIER_RESOLVE = 9;
    localparam int BIT_DEPTH_RESOLVE = 8;
    localparam int BIT_DEPTH_CLEAR  = 7;
    localparam int BIT_FAST_SPAN    = 6;
    localparam int BIT_CONTIG64     = 4;
    localparam int BIT_CONTIG32     = 3;
    localparam int BIT_DISP32       = 2;
    localparam int BIT_DISP16       = 1;
    localparam int BIT_DISP8        = 0;

    // Writable bits; everything else is reserved and reads as zero.
    localparam logic [31:0] CTRL_WRITE_MASK = 32'h0000_03DF;
    localparam logic [31:0] KERNEL_MASK     = 32'hFFFF_FFCE;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0002;
    localparam logic [31:0] WORD_RESET      = 32'h0000_0000;

    // Kernel word fields.
    localparam int ENTRY_LSB  = 6;
    localparam int BLOCKS_LSB = 1;

    // Subspans per aligned 8x8 pixel block, and pixels per block.
    localparam int SUBSPANS = 16;
    localparam int PIXELS   = 64;

    typedef enum logic [1:0] {
        PDD_SZ2,
        PDD_SZ4,
        PDD_SZ8,
        PDD_SZ16
    } pdd_size_type;

    // One aligned 8x8 pixel block from the rasterizer, pixel index y*8+x.
    typedef struct packed {
        logic [PIXELS-1:0] pixel_mask;
    } pdd_block_type;

    // One shader thread payload.
    typedef struct packed {
        pdd_size_type        size;
        logic                contiguous;
        logic [1:0]          kernel;
        logic [25:0]         entry;
        logic [2:0]          blocks;
        logic [SUBSPANS-1:0] subspans;
        logic [PIXELS-1:0]   pixel_mask;
        logic                hier_resolve;
        logic                hiz_reinit;
        logic                depth_resolve;
        logic                depth_clear;
    } pdd_payload_type;

endpackage

// ===== bench/pdd_shader_model.sv
`timescale 1ns/10ps
// Thread dispatcher stand-in. It takes payloads at once or stalls at random.
module pdd_shader_model (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic slow,
    output logic      pay_ready
);
    // With slow set, ready is high on about one edge in four, so payloads can stand across several edges.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pay_ready <= 1'b0;
        end else begin
            pay_ready <= slow ? ($urandom_range(0, 3) == 0) : 1'b1;
        end
    end
endmodule

// ===== bench/tb.sv
`timescale 1ns/10ps
module tb;
    logic                     clk = 1'b0;
    logic                     rst = 1'b1;
    logic [5:0]               address = 6'h00;
    logic                     read = 1'b0;
    logic                     write = 1'b0;
    logic [31:0]              writedata = 32'h0000_0000;
    logic [3:0]               byteenable = 4'h0;
    logic [31:0]              readdata;
    logic                     waitrequest;
    logic                     blk_valid = 1'b0;
    pdd_pkg::pdd_block_type   blk = '0;
    logic                     blk_ready;
    logic                     pay_valid;
    pdd_pkg::pdd_payload_type pay;
    logic                     pay_ready;
    logic [31:0]              bias_const;
    logic [31:0]              bias_scale;
    logic                     slow = 1'b0;
    logic [31:0]              ctrl;
    logic [31:0]              kword [4];
    logic                     hiz;
    logic [31:0]              rd;
    int                       bad_count = 0;
    int                       total_checks = 0;
    int                       cyc = 0;
    int                       npay = 0;
    pdd_pkg::pdd_payload_type exp_q [$];

    // Clock at 200 MHz.
    always #2.5 clk = ~clk;

    pdd_dispatch pdd_dispatch_i (.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .blk_valid(blk_valid), .blk(blk), .blk_ready(blk_ready), .pay_valid(pay_valid), .pay(pay),
        .pay_ready(pay_ready), .bias_const(bias_const), .bias_scale(bias_scale));
    pdd_shader_model pdd_shader_model_i (.clk(clk), .rst(rst), .slow(slow), .pay_ready(pay_ready));

    task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // A hang counts as a mismatch; the ceiling is far above the expected run.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            bad_count++;
            results();
        end
    end

    // One Avalon access; the request stands until waitrequest is low at an edge.
    task automatic bus_op(input logic wr, input logic [3:0] idx, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk);
        address    <= {idx, 2'b00};
        read       <= !wr;
        write      <= wr;
        writedata  <= d;
        byteenable <= be;
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        rd = readdata;
        read  <= 1'b0;
        write <= 1'b0;
    endtask

    // Control is changed only while idle, since flags are sampled at issue time.
    task automatic cfg(input logic [31:0] c, input logic h);
        ctrl = c;
        hiz  = h;
        bus_op(1'b1, pdd_pkg::IDX_DISPATCH_CTRL, c, 4'hF);
        bus_op(1'b1, pdd_pkg::IDX_DEPTH_CFG, {31'h0000_0000, h}, 4'hF);
        for (int k = 0; k < 4; k++) begin
            kword[k] = $urandom;
            bus_op(1'b1, (k == 0) ? pdd_pkg::IDX_KERNEL0 : pdd_pkg::IDX_KERNEL1 + 4'(k - 1), kword[k], 4'hF);
        end
    endtask

    // Reference model: fast span fill, subspan forming, then size choice per payload.
    function automatic void expect_block(input logic [63:0] m);
        logic [63:0]              pm;
        logic [3:0]               quad;
        logic [15:0]              rem;
        logic [15:0]              take;
        logic [1:0]               kx;
        int                       cnt;
        int                       k;
        pdd_pkg::pdd_payload_type p;
        pm   = m;
        quad = 4'h0;
        rem  = 16'h0000;
        for (int i = 0; i < 64; i++) quad[(i / 32) * 2 + (i % 8) / 4] |= m[i];
        for (int i = 0; i < 64; i++) begin
            pm[i] = pm[i] | (ctrl[6] & quad[(i / 32) * 2 + (i % 8) / 4]);
            rem[(i / 16) * 4 + (i % 8) / 2] |= pm[i];
        end
        while (rem != 16'h0000) begin
            cnt  = $countones(rem);
            take = 16'h0000;
            p    = '0;
            if (ctrl[4] && rem == 16'hFFFF) take = 16'hFFFF;
            else if (ctrl[3] && rem[7:0] == 8'hFF) take = 16'h00FF;
            else if (ctrl[3] && rem[15:8] == 8'hFF) take = 16'hFF00;
            p.contiguous = (take != 16'h0000);
            if (p.contiguous) kx = (take == 16'hFFFF) ? 2'h3 : 2'h2;
            else if (ctrl[2] && (cnt > 4 || ctrl[1:0] == 2'h0)) kx = 2'h2;
            else if (ctrl[1] && (cnt > 2 || !ctrl[0])) kx = 2'h1;
            else if (ctrl[0]) kx = 2'h0;
            else kx = 2'h1;
            k = 0;
            for (int s = 0; s < 16; s++) begin
                if (!p.contiguous && rem[s] && k < (2 << kx)) begin
                    take[s] = 1'b1;
                    k++;
                end
            end
            p.size          = pdd_pkg::pdd_size_type'(kx);
            p.kernel        = kx;
            p.entry         = kword[kx][31:6];
            p.blocks        = kword[kx][3:1];
            p.subspans      = take;
            p.pixel_mask    = pm;
            p.hier_resolve  = ctrl[9] & hiz;
            p.hiz_reinit    = ctrl[9] & hiz;
            p.depth_resolve = ctrl[8] & hiz;
            p.depth_clear   = ctrl[7];
            rem = rem & ~take;
            exp_q.push_back(p);
            npay++;
        end
    endfunction

    // Offer one block, then wait until all its payloads have been taken.
    task automatic send(input logic [63:0] m);
        expect_block(m);
        @(posedge clk);
        blk_valid      <= 1'b1;
        blk.pixel_mask <= m;
        @(posedge clk);
        while (blk_ready !== 1'b1) @(posedge clk);
        blk_valid <= 1'b0;
        while (exp_q.size() != 0) @(posedge clk);
        repeat (2) @(posedge clk);
    endtask

    // Each payload taken by the dispatcher is compared with the next expected one.
    always @(posedge clk) begin
        if (!rst && pay_valid === 1'b1 && pay_ready === 1'b1) begin
            if (exp_q.size() == 0) check("payload count", 128'h1, 128'h0);
            else check("payload", pay, exp_q.pop_front());
        end
    end

    initial begin
        logic [31:0] d;
        logic [31:0] e;
        logic [63:0] m;
        int          op;
        void'($urandom(32'h71a7_c669));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        // Reset values, reserved bits, unmapped and read-only places.
        bus_op(1'b0, pdd_pkg::IDX_DISPATCH_CTRL, 32'h0000_0000, 4'hF);
        check("ctrl reset", rd, pdd_pkg::CTRL_RESET);
        bus_op(1'b0, pdd_pkg::IDX_KERNEL0, 32'h0000_0000, 4'hF);
        check("kernel reset", rd, 32'h0000_0000);
        bus_op(1'b1, pdd_pkg::IDX_DISPATCH_CTRL, 32'hFFFF_FFFF, 4'hF);
        bus_op(1'b0, pdd_pkg::IDX_DISPATCH_CTRL, 32'h0000_0000, 4'hF);
        check("ctrl bits", rd, 32'h0000_03DF);
        bus_op(1'b1, pdd_pkg::IDX_KERNEL2, 32'hFFFF_FFFF, 4'hF);
        bus_op(1'b0, pdd_pkg::IDX_KERNEL2, 32'h0000_0000, 4'hF);
        check("kernel bits", rd, 32'hFFFF_FFCE);
        bus_op(1'b1, 4'h0, 32'hFFFF_FFFF, 4'hF);
        bus_op(1'b0, 4'h0, 32'h0000_0000, 4'hF);
        check("unmapped", rd, 32'h0000_0000);
        bus_op(1'b1, pdd_pkg::IDX_STATUS, 32'hFFFF_FFFF, 4'hF);
        bus_op(1'b0, pdd_pkg::IDX_STATUS, 32'h0000_0000, 4'hF);
        check("status idle", rd[1:0], 2'h0);
        d = $urandom;
        e = $urandom;
        bus_op(1'b1, pdd_pkg::IDX_BIAS_CONST, d, 4'hF);
        bus_op(1'b0, pdd_pkg::IDX_BIAS_CONST, 32'h0000_0000, 4'hF);
        check("bias const", rd, d);
        check("bias const out", bias_const, d);
        bus_op(1'b1, pdd_pkg::IDX_BIAS_SCALE, d, 4'hF);
        bus_op(1'b1, pdd_pkg::IDX_BIAS_SCALE, e, 4'h5);
        bus_op(1'b0, pdd_pkg::IDX_BIAS_SCALE, 32'h0000_0000, 4'hF);
        check("bias scale", rd, {d[31:24], e[23:16], d[15:8], e[7:0]});
        check("bias scale out", bias_scale, {d[31:24], e[23:16], d[15:8], e[7:0]});
        $display("test registers done");
        // Corner cases: contiguous modes, single sizes, fast span, resolves, empty block.
        cfg(32'h0000_0012, 1'b0); send(64'hFFFF_FFFF_FFFF_FFFF);
        cfg(32'h0000_000A, 1'b1); send(64'h0000_0000_FFFF_FFFF);
        cfg(32'h0000_0001, 1'b0); send(64'h8000_0000_0000_0001);
        cfg(32'h0000_0004, 1'b0); send(64'h0F0F_0000_F0F0_0303);
        cfg(32'h0000_00C2, 1'b1); send(64'h0000_0000_0000_0001);
        cfg(32'h0000_0203, 1'b1); send(64'hFFFF_0000_0000_FFFF);
        cfg(32'h0000_0106, 1'b0); send(64'h00FF_00FF_0000_0000);
        send(64'h0000_0000_0000_0000);
        $display("test corners done");
        // Random control and blocks; software keeps at most one depth operation on.
        for (int t = 0; t < 40; t++) begin
            op = $urandom_range(0, 3);
            cfg({22'h00_0000, op == 1, op == 2, op == 3, (op == 3) && ($urandom_range(0, 1) == 1), 1'b0,
                 5'($urandom)}, 1'($urandom));
            case ($urandom_range(0, 3))
                0: m = 64'hFFFF_FFFF_FFFF_FFFF;
                1: m = {$urandom, $urandom};
                2: m = {$urandom, $urandom} & {$urandom, $urandom} & {$urandom, $urandom};
                default: m = {$urandom, 32'hFFFF_FFFF};
            endcase
            slow <= 1'($urandom);
            send(m);
        end
        $display("test random done");
        // Every expected payload was issued once and the dispatcher is idle again.
        bus_op(1'b0, pdd_pkg::IDX_STATUS, 32'h0000_0000, 4'hF);
        check("status count", rd, {npay[15:0], 16'h0000});
        results();
    end
endmodule
